// ### logic/tpw_timer.sv
// 8-bit timer with clear-on-match, fast pwm and phase-correct pwm waveforms
// assumes one 100 MHz clock, synchronous reset, avalon-mm master with waitrequest
`timescale 1ns/1ps

module tpw_timer (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // avalon-mm slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // waveform pin
    output logic             pin_out,
    output logic             pin_oe
);
    import tpw_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        logic        ack;
        logic [31:0] rdata;
        logic [2:0]  mode;
        logic [1:0]  action;
        logic [2:0]  csel;
        logic [7:0]  cmp_buf;
        logic [7:0]  cmp_act;
        logic [7:0]  cnt;
        logic        up;
        logic        up_done;
        logic        ovf_flag;
        logic        cmpa_flag;
        logic        dir;
        logic        port;
        logic        wave;
        logic [9:0]  psc;
    } tpw_state_type;

    tpw_state_type st_ff;
    tpw_state_type nxt_st;

    logic        acc;
    logic        wr_acc;
    logic [31:0] wmerge;
    logic [9:0]  psc_mask;
    logic        tick;
    logic        is_fast;
    logic        is_pc;
    logic        is_clr;
    logic [7:0]  cmp_eff;
    logic [7:0]  top;
    logic        match;
    logic        up_phase;
    logic        cnt_wr;
    logic        at_top;
    logic        at_bottom;

    // ==========================================================
    // bus handshake: one wait cycle per request, answer on the second
    assign acc         = (read | write) & st_ff.ack;
    assign wr_acc      = write & st_ff.ack;
    assign waitrequest = (read | write) & ~st_ff.ack;
    assign readdata    = st_ff.rdata;
    assign cnt_wr      = wr_acc & (address == CNT_OFS) & byteenable[0];

    // byte-lane merge of write data over a zero base
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmerge[i*8 +: 8] = byteenable[i] ? writedata[i*8 +: 8] : 8'h00;
        end
    end

    // ==========================================================
    // prescaler tick selection
    always_comb begin
        unique case (st_ff.csel)
            3'h1:    psc_mask = PSC_DIV1;
            3'h2:    psc_mask = PSC_DIV8;
            3'h3:    psc_mask = PSC_DIV32;
            3'h4:    psc_mask = PSC_DIV64;
            3'h5:    psc_mask = PSC_DIV128;
            3'h6:    psc_mask = PSC_DIV256;
            3'h7:    psc_mask = PSC_DIV1024;
            default: psc_mask = PSC_DIV1;
        endcase
    end
    assign tick = (st_ff.csel != 3'h0) & ((st_ff.psc & psc_mask) == psc_mask);

    // ==========================================================
    // mode decode, top and compare selection
    assign is_fast  = (st_ff.mode == MODE_FAST_MAX) | (st_ff.mode == MODE_FAST_CMP);
    assign is_pc    = (st_ff.mode == MODE_PC_MAX) | (st_ff.mode == MODE_PC_CMP);
    assign is_clr   = (st_ff.mode == MODE_CLR);
    // pwm modes use the active copy loaded at top, others see the written value at once
    assign cmp_eff  = (is_fast | is_pc) ? st_ff.cmp_act : st_ff.cmp_buf;
    assign top      = (is_clr | (st_ff.mode == MODE_FAST_CMP) | (st_ff.mode == MODE_PC_CMP))
                      ? cmp_eff : CNT_MAX;
    assign match    = (st_ff.cnt == cmp_eff);
    assign at_top   = (st_ff.cnt == top);
    assign at_bottom = (st_ff.cnt == CNT_BOTTOM);
    // at bottom a match is an up match, at top a down match
    assign up_phase = at_bottom ? 1'b1 : (at_top ? 1'b0 : st_ff.up);

    // ==========================================================
    // pin override and direction
    assign pin_oe  = st_ff.dir;
    assign pin_out = (st_ff.action != ACT_NONE) ? st_ff.wave : st_ff.port;

    // ==========================================================
    // next state
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.ack   = (read | write) & ~st_ff.ack;
        nxt_st.psc   = st_ff.psc + 10'h001;
        // read data captured in the wait cycle, stands at the accept edge
        if (read & ~st_ff.ack) begin
            nxt_st.rdata = RDATA_RST;
            unique case (address)
                CTL_OFS: begin
                    nxt_st.rdata[MODE_LSB +: 3] = st_ff.mode;
                    nxt_st.rdata[ACT_LSB +: 2]  = st_ff.action;
                    nxt_st.rdata[CSEL_LSB +: 3] = st_ff.csel;
                end
                CMPA_OFS: nxt_st.rdata[7:0] = st_ff.cmp_buf;
                CNT_OFS:  nxt_st.rdata[7:0] = st_ff.cnt;
                FLAG_OFS: begin
                    nxt_st.rdata[OVF_BIT]  = st_ff.ovf_flag;
                    nxt_st.rdata[CMPA_BIT] = st_ff.cmpa_flag;
                end
                PIN_OFS: begin
                    nxt_st.rdata[DIR_BIT]  = st_ff.dir;
                    nxt_st.rdata[PORT_BIT] = st_ff.port;
                end
                STAT_OFS: begin
                    nxt_st.rdata[WAVE_BIT] = st_ff.wave;
                    nxt_st.rdata[UP_BIT]   = st_ff.up;
                end
                default: nxt_st.rdata = RDATA_RST;
            endcase
        end
        // register writes
        if (wr_acc) begin
            unique case (address)
                CTL_OFS: begin
                    if (byteenable[0]) begin
                        nxt_st.mode   = wmerge[MODE_LSB +: 3];
                        nxt_st.action = wmerge[ACT_LSB +: 2];
                    end
                    if (byteenable[1]) begin
                        nxt_st.csel = wmerge[CSEL_LSB +: 3];
                    end
                end
                CMPA_OFS: begin
                    if (byteenable[0]) begin
                        nxt_st.cmp_buf = wmerge[7:0];
                    end
                end
                CNT_OFS: begin
                    if (byteenable[0]) begin
                        nxt_st.cnt = wmerge[7:0];
                    end
                end
                FLAG_OFS: begin
                    if (wmerge[OVF_BIT]) begin
                        nxt_st.ovf_flag = 1'b0;
                    end
                    if (wmerge[CMPA_BIT]) begin
                        nxt_st.cmpa_flag = 1'b0;
                    end
                end
                PIN_OFS: begin
                    if (byteenable[0]) begin
                        nxt_st.dir  = wmerge[DIR_BIT];
                        nxt_st.port = wmerge[PORT_BIT];
                    end
                end
                default: nxt_st.mode = st_ff.mode;
            endcase
        end
        // non-pwm modes keep the active copy tracking the written value
        if (!(is_fast | is_pc)) begin
            nxt_st.cmp_act = st_ff.cmp_buf;
        end
        // counting; a bus write to the counter wins over the tick
        if (tick) begin
            if (match) begin
                nxt_st.cmpa_flag = 1'b1;   // set wins over clear
            end
            if (is_fast) begin
                if (at_top) begin
                    if (!cnt_wr) begin
                        nxt_st.cnt = CNT_BOTTOM;
                    end
                    nxt_st.ovf_flag = 1'b1;
                    nxt_st.cmp_act  = st_ff.cmp_buf;
                    if (st_ff.action == ACT_NONINV) begin
                        nxt_st.wave = 1'b1;
                    end else if (st_ff.action == ACT_INV) begin
                        nxt_st.wave = 1'b0;
                    end
                end else if (!cnt_wr) begin
                    nxt_st.cnt = st_ff.cnt + 8'h01;
                end
                // a match at top yields to the bottom action
                if (match && !(at_top && st_ff.action[1])) begin
                    unique case (st_ff.action)
                        ACT_TOGGLE: nxt_st.wave = ~st_ff.wave;
                        ACT_NONINV: nxt_st.wave = 1'b0;
                        ACT_INV:    nxt_st.wave = 1'b1;
                        ACT_NONE:   nxt_st.wave = st_ff.wave;
                    endcase
                end
            end else if (is_pc) begin
                if (st_ff.up) begin
                    if (at_top) begin
                        nxt_st.up      = 1'b0;
                        nxt_st.cmp_act = st_ff.cmp_buf;
                        if (!cnt_wr) begin
                            nxt_st.cnt = (top == CNT_BOTTOM) ? CNT_BOTTOM
                                                             : st_ff.cnt - 8'h01;
                        end
                    end else if (!cnt_wr) begin
                        nxt_st.cnt = st_ff.cnt + 8'h01;
                    end
                end else begin
                    if (at_bottom) begin
                        nxt_st.up       = 1'b1;
                        nxt_st.ovf_flag = 1'b1;
                        nxt_st.up_done  = 1'b0;
                        // missed up match last period: restore symmetry
                        if (!st_ff.up_done && cmp_eff != CNT_MAX && st_ff.action[1]) begin
                            nxt_st.wave = (st_ff.action == ACT_INV);
                        end
                        if (!cnt_wr) begin
                            nxt_st.cnt = st_ff.cnt + 8'h01;
                        end
                    end else if (!cnt_wr) begin
                        nxt_st.cnt = st_ff.cnt - 8'h01;
                    end
                end
                if (match) begin
                    if (up_phase) begin
                        nxt_st.up_done = 1'b1;
                    end
                    unique case (st_ff.action)
                        ACT_TOGGLE: nxt_st.wave = ~st_ff.wave;
                        ACT_NONINV: nxt_st.wave = ~up_phase;
                        ACT_INV:    nxt_st.wave = up_phase;
                        ACT_NONE:   nxt_st.wave = st_ff.wave;
                    endcase
                end
            end else begin
                nxt_st.up = 1'b1;
                if (st_ff.cnt == CNT_MAX) begin
                    nxt_st.ovf_flag = 1'b1;
                end
                if (!cnt_wr) begin
                    nxt_st.cnt = ((is_clr && match) || st_ff.cnt == CNT_MAX)
                                 ? CNT_BOTTOM : st_ff.cnt + 8'h01;
                end
                if (match) begin
                    unique case (st_ff.action)
                        ACT_TOGGLE: nxt_st.wave = ~st_ff.wave;
                        ACT_NONINV: nxt_st.wave = 1'b0;
                        ACT_INV:    nxt_st.wave = 1'b1;
                        ACT_NONE:   nxt_st.wave = st_ff.wave;
                    endcase
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff         <= '0;
            st_ff.rdata   <= RDATA_RST;
            st_ff.cmp_buf <= CMP_RST;
            st_ff.cmp_act <= CMP_RST;
            st_ff.psc     <= PSC_RST;
            st_ff.up      <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_clr_top_clear: assert property (
        tick && is_clr && match && !cnt_wr |=> st_ff.cnt == CNT_BOTTOM && st_ff.cmpa_flag)
        else $error("clear-on-match counter not cleared at compare");
    a_clr_wrap_ovf: assert property (
        tick && is_clr && st_ff.cnt == CNT_MAX |=> st_ff.ovf_flag)
        else $error("overflow flag missing at max wrap");
    a_clr_toggle: assert property (
        tick && is_clr && match && st_ff.action == ACT_TOGGLE |=> st_ff.wave != $past(st_ff.wave))
        else $error("toggle action did not invert output");
    a_clr_direct_cmp: assert property (
        wr_acc && address == CMPA_OFS && byteenable[0] && is_clr
        |=> cmp_eff == $past(writedata[7:0]))
        else $error("compare write not effective at once");
    a_fast_wrap_ovf: assert property (
        tick && is_fast && at_top && !cnt_wr |=> st_ff.cnt == CNT_BOTTOM && st_ff.ovf_flag)
        else $error("fast pwm did not clear and flag at top");
    a_fast_bottom_set: assert property (
        tick && is_fast && at_top && st_ff.action == ACT_NONINV |=> st_ff.wave)
        else $error("non-inverting output not set at bottom");
    a_pc_top_turn: assert property (
        tick && is_pc && st_ff.up && at_top && top != CNT_BOTTOM && !cnt_wr
        |=> !st_ff.up && st_ff.cnt == $past(st_ff.cnt) - 8'h01)
        else $error("phase-correct did not turn after one top cycle");
    a_pc_bottom_ovf: assert property (
        tick && is_pc && !st_ff.up && at_bottom |=> st_ff.ovf_flag && st_ff.up)
        else $error("phase-correct overflow flag missing at bottom");
    a_pin_hidden: assert property (
        !st_ff.dir |-> !pin_oe ##1 (st_ff.dir || !pin_oe))
        else $error("pin driven while direction is input");
    a_bus_answer: assert property (
        (read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered after one wait cycle");

    c_clr_toggle: cover property (tick && is_clr && match && st_ff.action == ACT_TOGGLE);
    c_fast_wrap:  cover property (tick && is_fast && at_top);
    c_pc_turn:    cover property (tick && is_pc && st_ff.up && at_top);
    c_flag_clash: cover property (tick && match && wr_acc && address == FLAG_OFS);

endmodule : tpw_timer

// ### inc/tpw_pkg.sv
// constants for the 8-bit waveform timer: register map, fields, reset values, modes
// assumes a 100 MHz system clock and a 32-bit avalon-mm register port
package tpw_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [4:0] CTL_OFS    = 5'h00;  // mode, output action, clock select
    localparam logic [4:0] CMPA_OFS   = 5'h04;  // compare_a_value
    localparam logic [4:0] CNT_OFS    = 5'h08;  // counter_value, read/write
    localparam logic [4:0] FLAG_OFS   = 5'h0C;  // event flags, write one to clear
    localparam logic [4:0] PIN_OFS    = 5'h10;  // pin direction and port data
    localparam logic [4:0] STAT_OFS   = 5'h14;  // live state, read only

    // ==========================================================
    // field positions
    localparam int MODE_LSB    = 0;   // waveform_mode_field [2:0]
    localparam int ACT_LSB     = 4;   // output_action_a_field [5:4]
    localparam int CSEL_LSB    = 8;   // clock select [10:8]
    localparam int OVF_BIT     = 0;   // overflow_flag
    localparam int CMPA_BIT    = 1;   // compare_a_flag
    localparam int DIR_BIT     = 0;   // pin drives when set
    localparam int PORT_BIT    = 1;   // normal port level
    localparam int WAVE_BIT    = 0;   // wave_out_a state in status
    localparam int UP_BIT      = 1;   // counting direction in status

    // ==========================================================
    // waveform modes and output actions
    localparam logic [2:0] MODE_NORMAL  = 3'h0;
    localparam logic [2:0] MODE_PC_MAX  = 3'h1;
    localparam logic [2:0] MODE_CLR     = 3'h2;
    localparam logic [2:0] MODE_FAST_MAX = 3'h3;
    localparam logic [2:0] MODE_PC_CMP  = 3'h5;
    localparam logic [2:0] MODE_FAST_CMP = 3'h7;
    localparam logic [1:0] ACT_NONE     = 2'h0;
    localparam logic [1:0] ACT_TOGGLE   = 2'h1;
    localparam logic [1:0] ACT_NONINV   = 2'h2;
    localparam logic [1:0] ACT_INV      = 2'h3;

    // ==========================================================
    // counter limits and prescaler masks (divisor minus one)
    localparam logic [7:0] CNT_BOTTOM   = 8'h00;
    localparam logic [7:0] CNT_MAX      = 8'hFF;
    localparam logic [9:0] PSC_DIV1     = 10'h000;
    localparam logic [9:0] PSC_DIV8     = 10'h007;
    localparam logic [9:0] PSC_DIV32    = 10'h01F;
    localparam logic [9:0] PSC_DIV64    = 10'h03F;
    localparam logic [9:0] PSC_DIV128   = 10'h07F;
    localparam logic [9:0] PSC_DIV256   = 10'h0FF;
    localparam logic [9:0] PSC_DIV1024  = 10'h3FF;
    localparam int FAST_PERIOD = 256;   // timer clocks per fast period at top max
    localparam int PC_PERIOD   = 510;   // timer clocks per phase-correct period at top max

    // ==========================================================
    // reset values
    localparam logic [31:0] RDATA_RST   = 32'h0000_0000;
    localparam logic [7:0]  CMP_RST     = 8'h00;
    localparam logic [9:0]  PSC_RST     = 10'h000;

endpackage : tpw_pkg

// ### testbench/tpw_load.sv
// load on the waveform pin: measures high time, period and edge count
// assumes the pin is pulled low whenever the timer does not drive it
`timescale 1ns/1ps

module tpw_load (
    // clock
    input  wire logic        clk,
    // pin from the timer
    input  wire logic        pin_out,
    input  wire logic        pin_oe,
    // measurements in clock cycles and an edge count
    output logic      [31:0] hi_len,
    output logic      [31:0] per_len,
    output logic      [31:0] edges
);
    // ==========================================================
    // pin level and timing
    logic        lvl_ff = 1'b0;
    logic [31:0] cyc = '0;
    logic [31:0] rise_at = '0;
    logic [31:0] edge_ff = '0;
    wire  logic  lvl = (pin_oe === 1'b1) ? pin_out : 1'b0;  // pull-down when released

    assign edges = edge_ff;

    // time each rise and fall on the clock
    always @(posedge clk) begin
        cyc <= cyc + 1;
        lvl_ff <= lvl;
        if (lvl && !lvl_ff) begin
            per_len <= cyc - rise_at;
            rise_at <= cyc;
        end
        if (!lvl && lvl_ff) hi_len <= cyc - rise_at;
        if (lvl !== lvl_ff) edge_ff <= edge_ff + 1;
    end
endmodule : tpw_load

// ### testbench/timer8_ctc_fast_phase_pwm_test.sv
// self-checking bench for the 8-bit waveform timer over avalon-mm
// assumes tpw_pkg, tpw_timer and the tpw_load pin model are compiled first
`timescale 1ns/1ps

module timer8_ctc_fast_phase_pwm_test;
    import tpw_pkg::*;
    // ==========================================================
    // signals
    logic        clk, rst, read, write, waitrequest, pin_out, pin_oe;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata, readdata, q, hi_len, per_len, edges, e0, seed;
    int          err_count, check_count, c;
    int          divs[7] = '{1, 8, 32, 64, 128, 256, 1024};

    tpw_timer uut (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .pin_out(pin_out), .pin_oe(pin_oe));
    tpw_load load (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .hi_len(hi_len),
        .per_len(per_len), .edges(edges));

    // ==========================================================
    // expectations and helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] a, input int s);
        return (32'(m) << MODE_LSB) | (32'(a) << ACT_LSB) | (32'(s) << CSEL_LSB);
    endfunction : ctl

    function automatic logic [31:0] fast_hi(input int v, input logic [1:0] a);
        return (a == ACT_NONINV) ? 32'(v + 1) : 32'(255 - v);
    endfunction : fast_hi

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one avalon transfer, held until waitrequest is sampled low on a rising edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic setup(input logic [31:0] cw, input int v, input int wait_n);
        bus(1'b1, CTL_OFS, cw);
        bus(1'b1, CMPA_OFS, 32'(v));
        bus(1'b1, CNT_OFS, 32'h0000_0000);
        repeat (wait_n) @(posedge clk);
    endtask : setup

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #500_000;
        err_count++;
        report_and_stop();
    end

    // ==========================================================
    // main sequence
    initial begin
        seed = 32'h0001_2ECC;  // 77516
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 5'h00;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // reset values and an unmapped read
        bus(1'b0, CTL_OFS, 32'h0000_0000);
        chk("ctl reset", 32'h0000_0000, q);
        bus(1'b0, 5'h18, 32'h0000_0000);
        chk("unmapped read", 32'h0000_0000, q);
        chk("oe reset", 32'h0000_0000, 32'(pin_oe));
        // port level shows when no waveform action is set
        bus(1'b1, CTL_OFS, ctl(MODE_CLR, ACT_NONE, 1));
        bus(1'b1, PIN_OFS, 32'h0000_0003);
        repeat (3) @(posedge clk);
        e0 = edges;
        repeat (60) @(posedge clk);
        chk("port high", 32'h0000_0001, 32'(pin_out));
        chk("no action edges", e0, edges);
        bus(1'b1, PIN_OFS, 32'h0000_0000);
        repeat (2) @(posedge clk);
        chk("oe off", 32'h0000_0000, 32'(pin_oe));
        bus(1'b1, PIN_OFS, 32'h0000_0001);
        // clear-on-match toggle at every prescale setting
        for (int s = 1; s < 8; s++) begin
            c = (s == 1) ? int'(xs() % 40) : 1;
            setup(ctl(MODE_CLR, ACT_TOGGLE, s), c, 6 * divs[s-1] * (c + 1) + 20);
            chk("clr period", 32'(2 * divs[s-1] * (c + 1)), per_len);
            chk("clr high", 32'(divs[s-1] * (c + 1)), hi_len);
        end
        // fast pwm at both polarities, top at max
        for (int a = 2; a < 4; a++) begin
            c = 1 + int'(xs() % 254);
            setup(ctl(MODE_FAST_MAX, 2'(a), 1), c, 800);
            chk("fast period", 32'h0000_0100, per_len);
            chk("fast high", fast_hi(c, 2'(a)), hi_len);
        end
        // fast pwm extremes: spike, then constant level
        setup(ctl(MODE_FAST_MAX, ACT_NONINV, 1), 0, 800);
        chk("spike high", 32'h0000_0001, hi_len);
        setup(ctl(MODE_FAST_MAX, ACT_NONINV, 1), 255, 600);
        e0 = edges;
        repeat (600) @(posedge clk);
        chk("max edges", e0, edges);
        chk("max level", 32'h0000_0001, 32'(pin_out));
        // fast pwm toggle with top at compare
        c = 1 + int'(xs() % 100);
        setup(ctl(MODE_FAST_CMP, ACT_TOGGLE, 1), c, 1000);
        chk("fast toggle period", 32'(2 * (c + 1)), per_len);
        // phase correct: high for twice the compare value
        c = 1 + int'(xs() % 254);
        setup(ctl(MODE_PC_MAX, ACT_NONINV, 1), c, 1600);
        chk("pc period", 32'(510), per_len);
        chk("pc high", 32'(2 * c), hi_len);
        setup(ctl(MODE_PC_MAX, ACT_NONINV, 1), 0, 1100);
        bus(1'b1, FLAG_OFS, 32'h0000_0003);
        e0 = edges;
        repeat (600) @(posedge clk);
        chk("pc zero edges", e0, edges);
        chk("pc zero level", 32'h0000_0000, 32'(pin_out));
        bus(1'b0, FLAG_OFS, 32'h0000_0000);
        chk("pc bottom overflow", 32'h0000_0001, q & 32'h0000_0001);
        // phase correct with top at compare: one period is twice the top
        c = 2 + int'(xs() % 99);
        setup(ctl(MODE_PC_CMP, ACT_NONINV, 1), c, 1000);
        chk("pc top cmp period", 32'(2 * c), per_len);
        // clear-on-match from a zero count keeps the count at or below the top and never overflows
        setup(ctl(MODE_CLR, ACT_TOGGLE, 1), 5, 20);
        bus(1'b1, FLAG_OFS, 32'h0000_0003);
        repeat (300) @(posedge clk);
        bus(1'b0, FLAG_OFS, 32'h0000_0000);
        chk("clr flags", 32'h0000_0002, q & 32'h0000_0003);
        // compare lowered below a running count is missed until the wrap
        bus(1'b1, CMPA_OFS, 32'h0000_00F0);
        bus(1'b1, CNT_OFS, 32'h0000_0080);
        bus(1'b1, FLAG_OFS, 32'h0000_0003);
        bus(1'b1, CMPA_OFS, 32'h0000_0005);
        bus(1'b0, CNT_OFS, 32'h0000_0000);
        chk("count past compare", 32'h0000_0080, q & 32'h0000_0080);
        repeat (200) @(posedge clk);
        bus(1'b0, FLAG_OFS, 32'h0000_0000);
        chk("wrap overflow", 32'h0000_0001, q & 32'h0000_0001);
        report_and_stop();
    end
endmodule : timer8_ctc_fast_phase_pwm_test
